// *** dcad_defines.vh ***
`ifndef DCAD_DEFINES_VH
`define DCAD_DEFINES_VH

// APB register byte offsets
`define DCAD_OFF_CTRL      12'h000
`define DCAD_OFF_OPERAND   12'h004
`define DCAD_OFF_OPHOLD    12'h008
`define DCAD_OFF_STATUS    12'h00C
`define DCAD_OFF_SUM       12'h010
`define DCAD_OFF_PRODUCT   12'h014
`define DCAD_OFF_WDATA     12'h018
`define DCAD_OFF_PTR_SEL   12'h01C
`define DCAD_OFF_PTR_DATA  12'h020
`define DCAD_OFF_PTR_CMD   12'h024
`define DCAD_OFF_CMD       12'h028

// Command codes written to the command register
`define DCAD_CMD_W         4
`define DCAD_CMD_NOP       4'h0
`define DCAD_CMD_LOAD      4'h1
`define DCAD_CMD_ADD       4'h2
`define DCAD_CMD_SUB       4'h3
`define DCAD_CMD_AND       4'h4
`define DCAD_CMD_OR        4'h5
`define DCAD_CMD_XOR       4'h6
`define DCAD_CMD_ADDC      4'h7
`define DCAD_CMD_SHL       4'h8
`define DCAD_CMD_SHR       4'h9
`define DCAD_CMD_ROL       4'hA
`define DCAD_CMD_ROR       4'hB
`define DCAD_CMD_MULT      4'hC
`define DCAD_CMD_ADDP      4'hD
`define DCAD_CMD_STORE     4'hE

// Control register fields
`define DCAD_CTRL_ISH_LSB  0
`define DCAD_CTRL_ISH_MSB  4
`define DCAD_CTRL_OSH_LSB  5
`define DCAD_CTRL_OSH_MSB  7
`define DCAD_CTRL_HIGH     8
`define DCAD_CTRL_SIGNED   9
`define DCAD_CTRL_PSS_LSB  10
`define DCAD_CTRL_PSS_MSB  11
`define DCAD_ISH_MAX       5'h10

// Status word one bit positions
`define DCAD_ST_CARRY      0
`define DCAD_ST_ZERO       1
`define DCAD_ST_NEG        2
`define DCAD_ST_EQ         3
`define DCAD_ST_PSS_LSB    4

// Product shift modes
`define DCAD_PSS_NONE      2'h0
`define DCAD_PSS_L1        2'h1
`define DCAD_PSS_L4        2'h2
`define DCAD_PSS_R6        2'h3

// Pointer commands
`define DCAD_PCMD_INC      3'h0
`define DCAD_PCMD_DEC      3'h1
`define DCAD_PCMD_ADDIDX   3'h2
`define DCAD_PCMD_SUBIDX   3'h3
`define DCAD_PCMD_CMP      3'h4
`define DCAD_PCMD_LOAD     3'h5

`define DCAD_PTR_COUNT     8
`define DCAD_PTR_AW        3

`endif

// *** dcad_ptr_file.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defines.vh"

// Eight 16-bit pointers with one write and two registered read ports
module dcad_ptr_file (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [2:0] wr_sel,
    input wire [15:0] wr_data,
    input wire [2:0] rd_sel,
    output reg [15:0] rd_data_q,
    output reg [15:0] idx_data_q
);
    wire [16*`DCAD_PTR_COUNT-1:0] flat;
    genvar g;

    // Storage per pointer; one word per scope keeps a single driver each
    generate
        for (g = 0; g < `DCAD_PTR_COUNT; g = g + 1) begin : g_ptr
            reg [15:0] word_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    word_q <= 16'h0000;
                end else if (wr_en && wr_sel == g) begin
                    word_q <= wr_data;
                end
            end
            assign flat[g*16 +: 16] = word_q;
        end
    endgenerate

    // Registered reads; pointer zero is always the index port
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_q <= 16'h0000;
            idx_data_q <= 16'h0000;
        end else begin
            rd_data_q <= flat[rd_sel*16 +: 16];
            idx_data_q <= flat[15:0];
        end
    end
endmodule // dcad_ptr_file

`default_nettype wire

// *** dcad_mult.v ***
`timescale 1ns/1ps
`default_nettype none

// Single-cycle 16x16 multiplier, signed or unsigned operands
module dcad_mult (
    input wire [15:0] op_a,
    input wire [15:0] op_b,
    input wire is_signed,
    output wire [31:0] product
);
    wire [16:0] ext_a;
    wire [16:0] ext_b;
    wire signed [33:0] full;

    assign ext_a = {is_signed & op_a[15], op_a};
    assign ext_b = {is_signed & op_b[15], op_b};
    assign full = $signed(ext_a) * $signed(ext_b);
    assign product = full[31:0];
endmodule // dcad_mult

`default_nettype wire

// *** dcad_datapath.v ***
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defines.vh"

// Notes on behaviour
// - A 32-bit sum register holds results, feeds operations, shifts and rotates.
// - Each 32-bit arithmetic or logic operation completes in one cycle.
// - Unit takes input or product shifter operand with sum; reports status.
// - Carry kept in status, fed to add-with-carry, used in shifts and rotates.
// - Input shifter moves 16-bit operand left 0 to 16 places, no extra cycle.
// - Output shifter shifts sum left 0 to 7, writes high or low half.
// - Multiplier forms 32-bit product from two 16-bit operands in one cycle.
// - Unsigned 16-bit pointer adder computes addresses from and to pointers.
// - Eight 16-bit pointers, numbered 0-7, chosen by a select field.
// - Pointer zero serves as step value and comparison value.
// - Product shifter applies left 0, 1, 4 or right 6, no extra cycle.
// - Two-bit select field in the control register chooses product scaling mode; status word one mirrors it.
// - 32-bit product register captures result; 16-bit register holds an operand.
module dcad_datapath (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [15:0] write_data_bus,
    output reg write_data_valid,
    output reg [15:0] pointer_address
);
    reg [11:0] ctrl_q;
    reg [15:0] operand_q;
    reg [15:0] operand_holding_register_q;
    reg [31:0] main_sum_register_q;
    reg [31:0] product_holding_register_q;
    reg carry_q;
    reg zero_q;
    reg neg_q;
    reg eq_q;
    reg [2:0] pointer_select_field_q;
    reg ptr_busy_q;
    reg [2:0] ptr_cmd_q;
    reg [15:0] ptr_load_q;
    reg [31:0] sum_d;
    reg carry_d;
    reg [31:0] product_scaled;
    reg [31:0] rdata_d;
    reg [15:0] ptr_new;
    reg ptr_wr;
    reg [32:0] wide;

    wire wr_acc;
    wire cmd_wr;
    wire [3:0] cmd;
    wire [4:0] in_shift;
    wire [2:0] out_shift;
    wire [1:0] product_shift_select;
    wire [31:0] input_shifter;
    wire [31:0] out_shifted;
    wire [31:0] product;
    wire [15:0] ptr_cur;
    wire [15:0] pointer_zero_index;
    wire [15:0] status_word_one;

    // APB access phase; the slave answers with zero wait states
    assign wr_acc = psel && penable && pwrite;
    assign cmd_wr = wr_acc && paddr == `DCAD_OFF_CMD;
    assign cmd = pwdata[`DCAD_CMD_W-1:0];

    // Control fields
    assign in_shift = ctrl_q[`DCAD_CTRL_ISH_MSB:`DCAD_CTRL_ISH_LSB];
    assign out_shift = ctrl_q[`DCAD_CTRL_OSH_MSB:`DCAD_CTRL_OSH_LSB];
    assign product_shift_select = ctrl_q[`DCAD_CTRL_PSS_MSB:`DCAD_CTRL_PSS_LSB];

    assign input_shifter = {16'h0000, operand_q} << ((in_shift > `DCAD_ISH_MAX) ? `DCAD_ISH_MAX : in_shift);

    // Output scaling of the sum register
    assign out_shifted = main_sum_register_q << out_shift;

    // Status word one view, with carry and mode bits
    assign status_word_one = {10'h000, product_shift_select, eq_q, neg_q, zero_q, carry_q};

    // Multiplier, one cycle, sign per control bit
    dcad_mult u_mult (
        .op_a(operand_holding_register_q),
        .op_b(operand_q),
        .is_signed(ctrl_q[`DCAD_CTRL_SIGNED]),
        .product(product)
    );

    // Product shifter; right shift keeps the sign
    always @* begin
        case (product_shift_select)
            `DCAD_PSS_NONE: product_scaled = product_holding_register_q;
            `DCAD_PSS_L1: product_scaled = {product_holding_register_q[30:0], 1'b0};
            `DCAD_PSS_L4: product_scaled = {product_holding_register_q[27:0], 4'h0};
            `DCAD_PSS_R6: product_scaled = {{6{product_holding_register_q[31]}}, product_holding_register_q[31:6]};
            default: product_scaled = product_holding_register_q;
        endcase
    end

    always @* begin
        sum_d = main_sum_register_q;
        carry_d = carry_q;
        wide = 33'h000000000;
        case (cmd)
            `DCAD_CMD_LOAD: sum_d = input_shifter;
            // Operand from input shifter with sum
            `DCAD_CMD_ADD: begin
                wide = {1'b0, main_sum_register_q} + {1'b0, input_shifter};
                sum_d = wide[31:0];
                carry_d = wide[32];
            end
            `DCAD_CMD_SUB: begin
                wide = {1'b0, main_sum_register_q} - {1'b0, input_shifter};
                sum_d = wide[31:0];
                carry_d = ~wide[32];
            end
            `DCAD_CMD_AND: sum_d = main_sum_register_q & input_shifter;
            `DCAD_CMD_OR: sum_d = main_sum_register_q | input_shifter;
            `DCAD_CMD_XOR: sum_d = main_sum_register_q ^ input_shifter;
            // Carry fed back for extended precision
            `DCAD_CMD_ADDC: begin
                wide = {1'b0, main_sum_register_q} + {1'b0, input_shifter} + {32'h00000000, carry_q};
                sum_d = wide[31:0];
                carry_d = wide[32];
            end
            `DCAD_CMD_SHL: begin
                sum_d = {main_sum_register_q[30:0], 1'b0};
                carry_d = main_sum_register_q[31];
            end
            `DCAD_CMD_SHR: begin
                sum_d = {1'b0, main_sum_register_q[31:1]};
                carry_d = main_sum_register_q[0];
            end
            `DCAD_CMD_ROL: begin
                sum_d = {main_sum_register_q[30:0], carry_q};
                carry_d = main_sum_register_q[31];
            end
            `DCAD_CMD_ROR: begin
                sum_d = {carry_q, main_sum_register_q[31:1]};
                carry_d = main_sum_register_q[0];
            end
            // Operand from product shifter with sum
            `DCAD_CMD_ADDP: begin
                wide = {1'b0, main_sum_register_q} + {1'b0, product_scaled};
                sum_d = wide[31:0];
                carry_d = wide[32];
            end
            default: sum_d = main_sum_register_q;
        endcase
    end

    // Sum register, carry and status flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_sum_register_q <= 32'h00000000;
            carry_q <= 1'b0;
            zero_q <= 1'b1;
            neg_q <= 1'b0;
        end else if (cmd_wr) begin
            main_sum_register_q <= sum_d;
            carry_q <= carry_d;
            zero_q <= (sum_d == 32'h00000000);
            neg_q <= sum_d[31];
        end else if (wr_acc && paddr == `DCAD_OFF_STATUS) begin
            carry_q <= pwdata[`DCAD_ST_CARRY];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            product_holding_register_q <= 32'h00000000;
            operand_holding_register_q <= 16'h0000;
        end else begin
            if (cmd_wr && cmd == `DCAD_CMD_MULT) begin
                product_holding_register_q <= product;
            end
            if (wr_acc && paddr == `DCAD_OFF_OPHOLD) begin
                operand_holding_register_q <= pwdata[15:0];
            end
        end
    end

    // Software control and operand registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 12'h000;
            operand_q <= 16'h0000;
            pointer_select_field_q <= 3'h0;
        end else if (wr_acc) begin
            if (paddr == `DCAD_OFF_CTRL) begin
                ctrl_q <= pwdata[11:0];
            end
            if (paddr == `DCAD_OFF_OPERAND) begin
                operand_q <= pwdata[15:0];
            end
            if (paddr == `DCAD_OFF_PTR_SEL) begin
                pointer_select_field_q <= pwdata[2:0];
            end
        end
    end

    // Store drives the chosen half on the write bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_data_bus <= 16'h0000;
            write_data_valid <= 1'b0;
        end else begin
            write_data_valid <= cmd_wr && cmd == `DCAD_CMD_STORE;
            if (cmd_wr && cmd == `DCAD_CMD_STORE) begin
                write_data_bus <= ctrl_q[`DCAD_CTRL_HIGH] ? out_shifted[31:16] : out_shifted[15:0];
            end
        end
    end

    // Pointer command is taken on the write and run one cycle later,
    // once the registered read ports show the selected pointer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_busy_q <= 1'b0;
            ptr_cmd_q <= 3'h0;
            ptr_load_q <= 16'h0000;
        end else begin
            ptr_busy_q <= wr_acc && paddr == `DCAD_OFF_PTR_CMD;
            if (wr_acc && paddr == `DCAD_OFF_PTR_CMD) begin
                ptr_cmd_q <= pwdata[2:0];
                ptr_load_q <= pwdata[31:16];
            end
        end
    end

    always @* begin
        ptr_new = ptr_cur;
        ptr_wr = ptr_busy_q;
        case (ptr_cmd_q)
            `DCAD_PCMD_INC: ptr_new = ptr_cur + 16'h0001;
            `DCAD_PCMD_DEC: ptr_new = ptr_cur - 16'h0001;
            `DCAD_PCMD_ADDIDX: ptr_new = ptr_cur + pointer_zero_index;
            `DCAD_PCMD_SUBIDX: ptr_new = ptr_cur - pointer_zero_index;
            `DCAD_PCMD_LOAD: ptr_new = ptr_load_q;
            default: ptr_wr = 1'b0;
        endcase
    end

    dcad_ptr_file u_ptrs (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(ptr_wr),
        .wr_sel(pointer_select_field_q),
        .wr_data(ptr_new),
        .rd_sel(pointer_select_field_q),
        .rd_data_q(ptr_cur),
        .idx_data_q(pointer_zero_index)
    );

    // Compare against pointer zero; address out
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_q <= 1'b0;
            pointer_address <= 16'h0000;
        end else begin
            if (ptr_busy_q && ptr_cmd_q == `DCAD_PCMD_CMP) begin
                eq_q <= (ptr_cur == pointer_zero_index);
            end
            pointer_address <= ptr_cur;
        end
    end

    // Read mux; unmapped addresses read zero with an error
    always @* begin
        case (paddr)
            `DCAD_OFF_CTRL: rdata_d = {20'h00000, ctrl_q};
            `DCAD_OFF_OPERAND: rdata_d = {16'h0000, operand_q};
            `DCAD_OFF_OPHOLD: rdata_d = {16'h0000, operand_holding_register_q};
            `DCAD_OFF_STATUS: rdata_d = {16'h0000, status_word_one};
            `DCAD_OFF_SUM: rdata_d = main_sum_register_q;
            `DCAD_OFF_PRODUCT: rdata_d = product_holding_register_q;
            `DCAD_OFF_WDATA: rdata_d = {16'h0000, write_data_bus};
            `DCAD_OFF_PTR_SEL: rdata_d = {29'h00000000, pointer_select_field_q};
            `DCAD_OFF_PTR_DATA: rdata_d = {16'h0000, ptr_cur};
            `DCAD_OFF_PTR_CMD: rdata_d = 32'h00000000;
            `DCAD_OFF_CMD: rdata_d = 32'h00000000;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Registered APB answer: ready rises in the access cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rdata_d : prdata;
            pslverr <= psel && !penable && (paddr > `DCAD_OFF_CMD || paddr[1:0] != 2'h0);
        end
    end
endmodule // dcad_datapath

`default_nettype wire

// *** dcad_bus_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far-side write bus sink, standing in for the core's data memory
module dcad_bus_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] write_data_bus,
    input wire logic write_data_valid,
    output logic [15:0] last_q,
    output logic [7:0] cnt_q
);
    // Take the word only in the valid cycle; the bus means nothing otherwise
    // store capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 16'h0000;
            cnt_q <= 8'h00;
        end else if (write_data_valid) begin
            last_q <= write_data_bus;
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // dcad_bus_sink
`default_nettype wire

// *** dcad_datapath_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defines.vh"
// Port-level watch on the datapath, with a shadow of loads and multiplies
module dcad_datapath_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] write_data_bus,
    input wire logic write_data_valid,
    input wire logic [15:0] pointer_address
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr, rd, ptr_wr, prod_ok_q, sum_ok_q;
    logic [11:0] ctl_q;
    logic [15:0] opnd_q, hold_q;
    logic [31:0] prod_q, sum_q;
    logic [4:0] ish;
    // Completed transfers; input shift count clamps at sixteen
    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    assign ptr_wr = wr && (paddr == `DCAD_OFF_PTR_SEL || paddr == `DCAD_OFF_PTR_CMD);
    assign ish = (ctl_q[4:0] > 5'h10) ? 5'h10 : ctl_q[4:0];
    // Sum shadow trusts only loads with bit 15 clear; the product shadow sign-extends per control bit 9
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 12'h000;
            opnd_q <= 16'h0000;
            hold_q <= 16'h0000;
            prod_q <= 32'h00000000;
            sum_q <= 32'h00000000;
            prod_ok_q <= 1'b0;
            sum_ok_q <= 1'b0;
        end else if (wr && paddr == `DCAD_OFF_CTRL) begin
            ctl_q <= pwdata[11:0];
        end else if (wr && paddr == `DCAD_OFF_OPERAND) begin
            opnd_q <= pwdata[15:0];
        end else if (wr && paddr == `DCAD_OFF_OPHOLD) begin
            hold_q <= pwdata[15:0];
        end else if (wr && paddr == `DCAD_OFF_CMD) begin
            sum_q <= {16'h0000, opnd_q} << ish;
            sum_ok_q <= pwdata[3:0] == `DCAD_CMD_LOAD && !opnd_q[15];
            if (pwdata[3:0] == `DCAD_CMD_MULT) begin
                prod_ok_q <= ish == 5'h00;
                prod_q <= ctl_q[9] ? {{16{opnd_q[15]}}, opnd_q} * {{16{hold_q[15]}}, hold_q}
                                   : {16'h0000, opnd_q} * {16'h0000, hold_q};
            end
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready ##1 !pready;
    endsequence
    sequence s_store;
        wr && paddr == `DCAD_OFF_CMD && pwdata[3:0] == `DCAD_CMD_STORE;
    endsequence
    a_ready_one_cycle: assert property (s_setup |-> s_answer)
        else $error("ready not a single pulse after setup");
    a_map_ok: assert property (pready && paddr <= `DCAD_OFF_CMD && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error flagged on a mapped word");
    a_store_pulse: assert property (s_store |=> write_data_valid ##1 !write_data_valid)
        else $error("store did not give one valid pulse");
    a_wdb_quiet: assert property ($changed(write_data_bus) |-> write_data_valid)
        else $error("write bus moved without valid");
    a_ptr_lag: assert property ($changed(pointer_address) |-> $past(ptr_wr) || $past(ptr_wr, 2)
        || $past(ptr_wr, 3) || $past(ptr_wr, 4))
        else $error("pointer output moved without a pointer write");
    a_mode_mirror: assert property (rd && paddr == `DCAD_OFF_STATUS |-> prdata[5:4] == ctl_q[11:10])
        else $error("status mode bits differ from control");
    a_product_value: assert property (rd && paddr == `DCAD_OFF_PRODUCT && prod_ok_q |-> prdata == prod_q)
        else $error("product value wrong");
    a_load_value: assert property (rd && paddr == `DCAD_OFF_SUM && sum_ok_q |-> prdata == sum_q)
        else $error("scaled load value wrong");
endmodule // dcad_datapath_properties
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcad_defines.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, write_data_valid, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [15:0] write_data_bus, pointer_address, last_w;
    logic [7:0] n_w;
    int bad_count, n_tests;
    logic [4:0] sh [4] = '{5'h00, 5'h05, 5'h10, 5'h14};
    logic [3:0] kd [4] = '{`DCAD_CMD_AND, `DCAD_CMD_OR, `DCAD_CMD_XOR, `DCAD_CMD_SUB};
    logic [31:0] ex [4] = '{32'h30, 32'hFFC, 32'hFCC, 32'hFFFFF1B4};
    logic [3:0] sr [4] = '{`DCAD_CMD_SHL, `DCAD_CMD_ROL, `DCAD_CMD_SHR, `DCAD_CMD_ROR};
    logic [31:0] sv [4] = '{32'h0, 32'h1, 32'h0, 32'h80000000};
    logic [2:0] sf [4] = '{3'h3, 3'h0, 3'h3, 3'h4};
    logic [31:0] pe [4] = '{32'h2FFFA, 32'h5FFF4, 32'h2FFFA0, 32'hBFF};
    logic [2:0] pc [5] = '{`DCAD_PCMD_INC, `DCAD_PCMD_INC, `DCAD_PCMD_ADDIDX, `DCAD_PCMD_SUBIDX, `DCAD_PCMD_DEC};
    logic [15:0] pv [5] = '{16'hFFFF, 16'h0000, 16'h0003, 16'h0000, 16'hFFFF};
    dcad_datapath i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .write_data_bus, .write_data_valid, .pointer_address);
    dcad_bus_sink i_sink (.pclk, .presetn, .write_data_bus, .write_data_valid, .last_q(last_w), .cnt_q(n_w));
    // Free-running core clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One bus transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        chk(pready, 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [11:0] c, input logic [15:0] v, input logic [3:0] k);
        xfer(1'b1, `DCAD_OFF_CTRL, {20'h0, c});
        xfer(1'b1, `DCAD_OFF_OPERAND, {16'h0, v});
        xfer(1'b1, `DCAD_OFF_CMD, {28'h0, k});
    endtask
    // Pointer reads are registered twice, so let them settle
    task automatic ptr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (2) @(posedge pclk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog, far beyond the roughly six hundred cycles the run needs
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
        chk(rv & 32'h37, 32'h2);
        // Carry is writable from software
        xfer(1'b1, `DCAD_OFF_STATUS, 32'h1);
        xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
        chk(rv & 32'h7, 32'h3);
        xfer(1'b0, 12'h02C, 32'h0);
        chk({rv[30:0], er}, 32'h1);
        foreach (sh[i]) begin
            op({7'h00, sh[i]}, 16'h4321, `DCAD_CMD_LOAD);
            xfer(1'b0, `DCAD_OFF_SUM, 32'h0);
            chk(rv, 32'h4321 << (sh[i] > 5'h10 ? 5'h10 : sh[i]));
        end
        // Carry out of bit 31, then fed back by add-with-carry
        op(12'h010, 16'hFFFF, `DCAD_CMD_LOAD);
        op(12'h010, 16'h0001, `DCAD_CMD_ADD);
        xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
        chk(rv & 32'h7, 32'h3);
        op(12'h000, 16'h0005, `DCAD_CMD_ADDC);
        xfer(1'b0, `DCAD_OFF_SUM, 32'h0);
        chk(rv, 32'h6);
        foreach (kd[i]) begin
            op(12'h000, 16'h00F0, `DCAD_CMD_LOAD);
            op(12'h000, 16'h0F3C, kd[i]);
            xfer(1'b0, `DCAD_OFF_SUM, 32'h0);
            chk(rv, ex[i]);
        end
        op(12'h010, 16'h8000, `DCAD_CMD_LOAD);
        foreach (sr[i]) begin
            op(12'h000, 16'h0000, sr[i]);
            xfer(1'b0, `DCAD_OFF_SUM, 32'h0);
            chk(rv, sv[i]);
            xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
            chk(rv[2:0], sf[i]);
        end
        xfer(1'b1, `DCAD_OFF_OPHOLD, 32'hFFFE);
        for (int i = 0; i < 2; i++) begin
            op(i ? 12'h000 : 12'h200, 16'h0003, `DCAD_CMD_MULT);
            xfer(1'b0, `DCAD_OFF_PRODUCT, 32'h0);
            chk(rv, i ? 32'h2FFFA : 32'hFFFFFFFA);
        end
        foreach (pe[i]) begin
            op({i[1:0], 10'h000}, 16'h0000, `DCAD_CMD_LOAD);
            xfer(1'b1, `DCAD_OFF_CMD, {28'h0, `DCAD_CMD_ADDP});
            xfer(1'b0, `DCAD_OFF_SUM, 32'h0);
            chk(rv, pe[i]);
            xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
            chk(rv[5:4], i[1:0]);
        end
        // Widest output shift, low half then high half
        for (int i = 0; i < 2; i++) begin
            op(12'h004, 16'h1234, `DCAD_CMD_LOAD);
            op({3'h0, i[0], 8'hE0}, 16'h0000, `DCAD_CMD_STORE);
            repeat (2) @(posedge pclk);
            chk({n_w, last_w}, {i[7:0] + 8'h01, i ? 16'h0091 : 16'hA000});
            xfer(1'b0, `DCAD_OFF_WDATA, 32'h0);
            chk(rv, {16'h0, i ? 16'h0091 : 16'hA000});
        end
        for (int i = 7; i >= 0; i--) begin
            ptr(`DCAD_OFF_PTR_SEL, i);
            ptr(`DCAD_OFF_PTR_CMD, {i[2:0], 13'h0003, 16'h0005});
        end
        for (int i = 0; i < 8; i++) begin
            ptr(`DCAD_OFF_PTR_SEL, i);
            xfer(1'b0, `DCAD_OFF_PTR_DATA, 32'h0);
            chk({pointer_address, rv[15:0]}, {2{i[2:0], 13'h0003}});
        end
        ptr(`DCAD_OFF_PTR_SEL, 32'h5);
        ptr(`DCAD_OFF_PTR_CMD, 32'hFFFE0005);
        foreach (pc[i]) begin
            ptr(`DCAD_OFF_PTR_CMD, {29'h0, pc[i]});
            xfer(1'b0, `DCAD_OFF_PTR_DATA, 32'h0);
            chk(rv[15:0], pv[i]);
        end
        for (int i = 0; i < 2; i++) begin
            ptr(`DCAD_OFF_PTR_CMD, i ? 32'h00040005 : 32'h00030005);
            ptr(`DCAD_OFF_PTR_CMD, {29'h0, `DCAD_PCMD_CMP});
            xfer(1'b0, `DCAD_OFF_STATUS, 32'h0);
            chk(rv[3], !i[0]);
        end
        close_out();
    end
endmodule // tb
bind dcad_datapath dcad_datapath_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .write_data_bus, .write_data_valid, .pointer_address);
`default_nettype wire
